// file: tag_cmd_pkg.sv
// Functional notes
// - multi-page read takes first page 00h to last page of the variant
// - page outside the command's range gets a NAK, no data, no change
// - read-protected and unauthenticated: NAK if range reaches protection start
// - authenticated: reads and writes run as if unprotected
// - password and password_ack pages read back as all zero bytes
// - page write A2h, page, 4 data bytes, CRC; data stored to page
// - page write takes pages 02h to last page of the variant
// - no write alters a page locked by static, dynamic or config locks
// - write-protected and unauthenticated: NAK at or above protection start
// - pages 2, 3 and the dynamic lock page are written tear-safe
// - legacy write A0h takes 16 bytes, stores bytes 0 to 3
// - legacy write takes pages 00h to last page of the variant
// - counter_read 39h with 02h returns 24-bit counter as 3 bytes plus CRC
// - counter_protect_bit set and unauthenticated: counter_read gets a NAK
// - authenticated: protected counter_read returns value and CRC
// - errors are answered by a 4-bit NAK frame
// - protection_start_page is the first protected page, all above too
//
// package of constants and carriers for the tag command handler.
// assumes one 100 MHz clock and a framing layer that hands over whole bytes.
package tag_cmd_pkg;
  // command codes and arguments
  localparam logic [7:0] CMD_FAST_READ = 8'h3A;
  localparam logic [7:0] CMD_WRITE = 8'hA2;
  localparam logic [7:0] CMD_COMPAT = 8'hA0;
  localparam logic [7:0] CMD_COUNTER = 8'h39;
  localparam logic [7:0] COUNTER_ARG = 8'h02;
  // page map
  localparam logic [7:0] FIRST_PAGE = 8'h00;
  localparam logic [7:0] FIRST_WR_PAGE = 8'h02;
  localparam logic [7:0] LAST_PAGE_SMALL = 8'h2C;
  localparam logic [7:0] LAST_PAGE_LARGE = 8'hE6;
  localparam logic [7:0] DYN_PAGE_SMALL = 8'h28;
  localparam logic [7:0] DYN_PAGE_LARGE = 8'hE2;
  localparam logic [7:0] STATIC_LOCK_PAGE = 8'h02;
  localparam logic [7:0] CC_PAGE = 8'h03;
  localparam logic [7:0] STATIC_LAST = 8'h0F;
  localparam logic [7:0] DYN_FIRST = 8'h10;
  localparam int DYN_BITS = 24;
  // frame lengths in bytes, CRC included
  localparam logic [4:0] LEN_FAST = 5'h05;
  localparam logic [4:0] LEN_COUNTER = 5'h04;
  localparam logic [4:0] LEN_WRITE = 5'h08;
  localparam logic [4:0] LEN_COMPAT1 = 5'h04;
  localparam logic [4:0] LEN_COMPAT2 = 5'h12;
  localparam int BUF_BYTES = 18;
  localparam logic [1:0] COUNTER_LAST_BYTE = 2'h2;
  localparam logic [1:0] PAGE_LAST_BYTE = 2'h3;
  // 4-bit answers
  localparam logic [3:0] ACK_CODE = 4'hA;
  localparam logic [3:0] NAK_ARG = 4'h0;
  localparam logic [3:0] NAK_CRC = 4'h1;
  // CRC_A
  localparam logic [15:0] CRC_INIT = 16'h6363;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PROT_START = 8'h04;
  localparam logic [7:0] OFF_COUNTER = 8'h08;
  localparam logic [7:0] OFF_PAGE_INDEX = 8'h0C;
  localparam logic [7:0] OFF_PAGE_DATA = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  // control bits
  localparam int CTRL_AUTH = 0;
  localparam int CTRL_PROT_RW = 1;
  localparam int CTRL_CNT_PROT = 2;
  localparam int CTRL_CFG_LOCK = 3;
  localparam logic [7:0] PROT_START_RESET = 8'hFF;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIMEOUT_SHORT_MS = 5;
  localparam int TIMEOUT_LONG_MS = 10;
  localparam int TIMEOUT_LONG_CYC = TIMEOUT_LONG_MS * 1000000 / CLK_PERIOD_NS;
  localparam int WRITE_TIME_US = 4000;
  localparam int WRITE_CYC = WRITE_TIME_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [1:0] {ST_RX, ST_EXEC, ST_SEND, ST_PROG} fsm_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } rx_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic short_frame;
  } tx_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avs_req_t;
endpackage

// file: crc_a_step.sv
// one-byte step of the ISO 14443 type A CRC, lsb first.
// assumes the caller holds the running value in its own state.
`timescale 1ns/10ps
module crc_a_step (
  // running value and new byte
  input wire logic [15:0] crc_in,
  input wire logic [7:0] byte_in,
  // updated value
  output logic [15:0] crc_out
);
  // bitwise shift register, unrolled by the loop
  always_comb begin
    crc_out = crc_in ^ {8'h00, byte_in};
    for (int i = 0; i < 8; i++) begin
      crc_out = crc_out[0] ? ((crc_out >> 1) ^ tag_cmd_pkg::CRC_POLY) : (crc_out >> 1);
    end
  end
endmodule

// file: tag_memory_command_handler.sv
// page memory command handler: multi-page read, page write, legacy write, counter_read.
// assumes a framer delivers received bytes with CRC and sends tx bytes or 4-bit answers.
//
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
module tag_memory_command_handler #(
  parameter logic [7:0] LAST_PAGE = tag_cmd_pkg::LAST_PAGE_SMALL,
  parameter logic [7:0] DYN_LOCK_PAGE = tag_cmd_pkg::DYN_PAGE_SMALL,
  parameter logic [7:0] CFG_FIRST_PAGE = 8'h29,
  parameter logic [7:0] PWD_PAGE = 8'h2B,
  parameter logic [7:0] PASSWORD_ACK_PAGE = 8'h2C,
  parameter int DYN_GROUP = 2,
  parameter int WRITE_CYCLES = tag_cmd_pkg::WRITE_CYC
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  // register bus
  input wire tag_cmd_pkg::avs_req_t avs_req_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // received frame bytes
  input wire tag_cmd_pkg::rx_t rx_in,
  input wire logic rx_valid_in,
  input wire logic field_in,
  // response bytes
  output tag_cmd_pkg::tx_t tx_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in
);
  localparam int PAGES = int'(LAST_PAGE) + 1;
  localparam int PROG_W = $clog2(WRITE_CYCLES + 1);

  typedef struct packed {
    tag_cmd_pkg::fsm_t fsm;
    logic [tag_cmd_pkg::BUF_BYTES-1:0][7:0] buff;
    logic [4:0] len;
    logic ovf;
    logic [15:0] crc;
    logic compat_pend;
    logic [7:0] compat_page;
    logic [7:0] rd_page;
    logic [7:0] rd_end;
    logic [1:0] rd_byte;
    logic cnt_mode;
    logic [1:0] crc_phase;
    logic [15:0] tx_crc;
    tag_cmd_pkg::tx_t tx;
    logic tx_valid;
    logic [7:0] wr_page;
    logic [31:0] wr_data;
    logic tear_page;
    logic [PROG_W-1:0] prog_cnt;
    logic [3:0] ctrl;
    logic [7:0] prot_start;
    logic [23:0] counter;
    logic [7:0] page_index;
    logic [7:0] last_cmd;
    logic [3:0] last_nak;
    logic [7:0] nak_count;
    logic bus_ack;
    logic [31:0] rdata;
    logic [PAGES-1:0][31:0] mem;
  } state_t;

  state_t s;
  state_t n;
  logic [15:0] rx_crc_next;
  logic [15:0] tx_crc_next;
  logic [7:0] src_byte;
  logic [15:0] static_bits;
  logic [tag_cmd_pkg::DYN_BITS-1:0] dyn_bits;
  logic auth;
  logic read_locked;
  logic exec_go;
  logic crc_ok;
  logic short_resp;
  logic [3:0] code;
  logic [31:0] page_word;

  // lock decode from the lock pages and the config lock bit
  function automatic logic page_locked(input logic [7:0] p, input logic [15:0] st,
                                       input logic [tag_cmd_pkg::DYN_BITS-1:0] dy,
                                       input logic cfg);
    int grp;
    grp = (int'(p) - int'(tag_cmd_pkg::DYN_FIRST)) / DYN_GROUP;
    if (p >= tag_cmd_pkg::CC_PAGE && p <= tag_cmd_pkg::STATIC_LAST)
      return st[p[3:0]];
    if (p >= tag_cmd_pkg::DYN_FIRST && p < DYN_LOCK_PAGE && grp < tag_cmd_pkg::DYN_BITS)
      return dy[grp];
    return cfg && p >= CFG_FIRST_PAGE;
  endfunction

  // write admission shared by both write commands
  function automatic logic wr_ok(input logic [7:0] p, input logic [7:0] lo,
                                 input logic [15:0] st,
                                 input logic [tag_cmd_pkg::DYN_BITS-1:0] dy,
                                 input logic cfg, input logic au, input logic [7:0] ps);
    return p >= lo && p <= LAST_PAGE && !page_locked(p, st, dy, cfg) && (au || p < ps);
  endfunction

  // rx CRC runs on every received byte; residue zero means a good frame
  crc_a_step rx_crc_u (
    .crc_in(s.crc),
    .byte_in(rx_in.data),
    .crc_out(rx_crc_next)
  );

  crc_a_step tx_crc_u (
    .crc_in(s.tx_crc),
    .byte_in(src_byte),
    .crc_out(tx_crc_next)
  );

  // lock words, authentication and the byte that a read streams next
  always_comb begin
    static_bits = s.mem[tag_cmd_pkg::STATIC_LOCK_PAGE][31:16];
    dyn_bits = s.mem[DYN_LOCK_PAGE][23:0];
    auth = s.ctrl[tag_cmd_pkg::CTRL_AUTH];
    read_locked = s.ctrl[tag_cmd_pkg::CTRL_PROT_RW] && !auth;
    exec_go = ce_in && s.fsm == tag_cmd_pkg::ST_EXEC && (!s.tx_valid || tx_ready_in);
    crc_ok = s.crc == tag_cmd_pkg::CRC_RESIDUE && !s.ovf;
    page_word = s.mem[s.rd_page];
    if (s.rd_page == PWD_PAGE || s.rd_page == PASSWORD_ACK_PAGE)
      page_word = '0;
    src_byte = s.cnt_mode ? s.counter[s.rd_byte*8 +: 8] : page_word[s.rd_byte*8 +: 8];
  end

  // next-state logic for bus, receiver, decoder, sender and programming
  always_comb begin
    n = s;
    short_resp = 1'b0;
    code = tag_cmd_pkg::NAK_ARG;
    // one wait cycle per access; write lands when waitrequest is low
    n.bus_ack = (avs_req_in.read || avs_req_in.write) && !s.bus_ack;
    if (avs_req_in.read && !s.bus_ack) begin
      unique case (avs_req_in.address)
        tag_cmd_pkg::OFF_CTRL: n.rdata = {28'h0000000, s.ctrl};
        tag_cmd_pkg::OFF_PROT_START: n.rdata = {24'h000000, s.prot_start};
        tag_cmd_pkg::OFF_COUNTER: n.rdata = {8'h00, s.counter};
        tag_cmd_pkg::OFF_PAGE_INDEX: n.rdata = {24'h000000, s.page_index};
        tag_cmd_pkg::OFF_PAGE_DATA: n.rdata = s.mem[s.page_index];
        tag_cmd_pkg::OFF_STATUS: n.rdata = {s.fsm, s.compat_pend, 5'h00, s.nak_count,
                                            4'h0, s.last_nak, s.last_cmd};
        default: n.rdata = 32'h00000000;
      endcase
    end
    if (avs_req_in.write && s.bus_ack) begin
      unique case (avs_req_in.address)
        tag_cmd_pkg::OFF_CTRL:
          if (avs_req_in.byteenable[0]) n.ctrl = avs_req_in.writedata[3:0];
        tag_cmd_pkg::OFF_PROT_START:
          if (avs_req_in.byteenable[0]) n.prot_start = avs_req_in.writedata[7:0];
        tag_cmd_pkg::OFF_COUNTER:
          for (int b = 0; b < 3; b++)
            if (avs_req_in.byteenable[b]) n.counter[b*8 +: 8] = avs_req_in.writedata[b*8 +: 8];
        tag_cmd_pkg::OFF_PAGE_INDEX:
          if (avs_req_in.byteenable[0]) n.page_index = avs_req_in.writedata[7:0];
        tag_cmd_pkg::OFF_PAGE_DATA:
          for (int b = 0; b < 4; b++)
            if (avs_req_in.byteenable[b] && s.page_index <= LAST_PAGE)
              n.mem[s.page_index][b*8 +: 8] = avs_req_in.writedata[b*8 +: 8];
        default: ;
      endcase
    end
    // a taken tx byte frees the holding register
    if (s.tx_valid && tx_ready_in)
      n.tx_valid = 1'b0;
    unique case (s.fsm)
      tag_cmd_pkg::ST_RX: begin
        // bytes outside this state are dropped: the reader waits for the answer
        if (rx_valid_in) begin
          if (s.len < 5'(tag_cmd_pkg::BUF_BYTES))
            n.buff[s.len] = rx_in.data;
          else
            n.ovf = 1'b1;
          if (s.len != 5'h1F)
            n.len = s.len + 5'h01;
          n.crc = rx_crc_next;
          if (rx_in.last)
            n.fsm = tag_cmd_pkg::ST_EXEC;
        end
      end
      tag_cmd_pkg::ST_EXEC: begin
        if (!s.tx_valid || tx_ready_in) begin
          short_resp = 1'b1;
          n.fsm = tag_cmd_pkg::ST_RX;
          n.crc = tag_cmd_pkg::CRC_INIT;
          n.len = 5'h00;
          n.ovf = 1'b0;
          n.last_cmd = s.buff[0];
          n.rd_byte = 2'h0;
          n.crc_phase = 2'h0;
          n.tx_crc = tag_cmd_pkg::CRC_INIT;
          if (!crc_ok) begin
            code = tag_cmd_pkg::NAK_CRC;
            n.compat_pend = 1'b0;
          end else if (s.compat_pend) begin
            n.compat_pend = 1'b0;
            if (s.len == tag_cmd_pkg::LEN_COMPAT2) begin
              short_resp = 1'b0;
              n.wr_page = s.compat_page;
              n.wr_data = {s.buff[3], s.buff[2], s.buff[1], s.buff[0]};
              n.fsm = tag_cmd_pkg::ST_PROG;
            end
          end else begin
            case (s.buff[0])
              tag_cmd_pkg::CMD_FAST_READ:
                if (s.len == tag_cmd_pkg::LEN_FAST && s.buff[1] <= LAST_PAGE
                    && s.buff[2] <= LAST_PAGE && s.buff[2] >= s.buff[1]
                    && !(read_locked && s.buff[2] >= s.prot_start)) begin
                  short_resp = 1'b0;
                  n.cnt_mode = 1'b0;
                  n.rd_page = s.buff[1];
                  n.rd_end = s.buff[2];
                  n.fsm = tag_cmd_pkg::ST_SEND;
                end
              tag_cmd_pkg::CMD_COUNTER:
                if (s.len == tag_cmd_pkg::LEN_COUNTER && s.buff[1] == tag_cmd_pkg::COUNTER_ARG
                    && !(s.ctrl[tag_cmd_pkg::CTRL_CNT_PROT] && !auth)) begin
                  short_resp = 1'b0;
                  n.cnt_mode = 1'b1;
                  n.fsm = tag_cmd_pkg::ST_SEND;
                end
              tag_cmd_pkg::CMD_WRITE:
                if (s.len == tag_cmd_pkg::LEN_WRITE && wr_ok(s.buff[1],
                    tag_cmd_pkg::FIRST_WR_PAGE, static_bits, dyn_bits,
                    s.ctrl[tag_cmd_pkg::CTRL_CFG_LOCK], auth, s.prot_start)) begin
                  short_resp = 1'b0;
                  n.wr_page = s.buff[1];
                  n.wr_data = {s.buff[5], s.buff[4], s.buff[3], s.buff[2]};
                  n.fsm = tag_cmd_pkg::ST_PROG;
                end
              tag_cmd_pkg::CMD_COMPAT:
                if (s.len == tag_cmd_pkg::LEN_COMPAT1 && wr_ok(s.buff[1],
                    tag_cmd_pkg::FIRST_PAGE, static_bits, dyn_bits,
                    s.ctrl[tag_cmd_pkg::CTRL_CFG_LOCK], auth, s.prot_start)) begin
                  code = tag_cmd_pkg::ACK_CODE;
                  n.compat_pend = 1'b1;
                  n.compat_page = s.buff[1];
                end
              default: ;
            endcase
          end
          if (n.fsm == tag_cmd_pkg::ST_PROG) begin
            n.tear_page = n.wr_page == tag_cmd_pkg::STATIC_LOCK_PAGE
                || n.wr_page == tag_cmd_pkg::CC_PAGE || n.wr_page == DYN_LOCK_PAGE;
            n.prog_cnt = PROG_W'(WRITE_CYCLES - 1);
            // ordinary pages change at once in full; a tear leaves the new bytes in place
            if (!n.tear_page)
              n.mem[n.wr_page] = n.wr_data;
          end
          if (short_resp) begin
            n.tx = '{data: {4'h0, code}, last: 1'b1, short_frame: 1'b1};
            n.tx_valid = 1'b1;
            if (code != tag_cmd_pkg::ACK_CODE) begin
              n.last_nak = code;
              n.nak_count = s.nak_count + 8'h01;
            end
          end
        end
      end
      tag_cmd_pkg::ST_SEND: begin
        // whole answer streams as one frame; no chaining back-pressure beyond ready
        if (!s.tx_valid || tx_ready_in) begin
          n.tx_valid = 1'b1;
          unique case (s.crc_phase)
            2'h0: begin
              n.tx = '{data: src_byte, last: 1'b0, short_frame: 1'b0};
              n.tx_crc = tx_crc_next;
              n.rd_byte = s.rd_byte + 2'h1;
              if (s.cnt_mode && s.rd_byte == tag_cmd_pkg::COUNTER_LAST_BYTE)
                n.crc_phase = 2'h1;
              if (!s.cnt_mode && s.rd_byte == tag_cmd_pkg::PAGE_LAST_BYTE) begin
                if (s.rd_page == s.rd_end)
                  n.crc_phase = 2'h1;
                else
                  n.rd_page = s.rd_page + 8'h01;
              end
            end
            2'h1: begin
              n.tx = '{data: s.tx_crc[7:0], last: 1'b0, short_frame: 1'b0};
              n.crc_phase = 2'h2;
            end
            default: begin
              n.tx = '{data: s.tx_crc[15:8], last: 1'b1, short_frame: 1'b0};
              n.fsm = tag_cmd_pkg::ST_RX;
            end
          endcase
        end
      end
      tag_cmd_pkg::ST_PROG: begin
        if (!field_in) begin
          n.fsm = tag_cmd_pkg::ST_RX;
        end else if (s.prog_cnt != '0) begin
          n.prog_cnt = s.prog_cnt - PROG_W'(1);
        end else if (!s.tx_valid || tx_ready_in) begin
          // tear-safe pages commit only once the whole write time has passed
          if (s.tear_page)
            n.mem[s.wr_page] = s.wr_data;
          n.tx = '{data: {4'h0, tag_cmd_pkg::ACK_CODE}, last: 1'b1, short_frame: 1'b1};
          n.tx_valid = 1'b1;
          n.fsm = tag_cmd_pkg::ST_RX;
        end
      end
    endcase
  end

  // single state register, frozen while the clock enable is low
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s <= '0;
      s.fsm <= tag_cmd_pkg::ST_RX;
      s.crc <= tag_cmd_pkg::CRC_INIT;
      s.tx_crc <= tag_cmd_pkg::CRC_INIT;
      s.prot_start <= tag_cmd_pkg::PROT_START_RESET;
    end else if (ce_in) begin
      s <= n;
    end
  end

  assign avs_waitrequest_out = (avs_req_in.read || avs_req_in.write) && !s.bus_ack;
  assign avs_readdata_out = s.rdata;
  assign tx_out = s.tx;
  assign tx_valid_out = s.tx_valid;

  a_range_nak: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    exec_go && crc_ok && !s.compat_pend && s.buff[0] == tag_cmd_pkg::CMD_FAST_READ
    && s.buff[1] > LAST_PAGE |=> s.tx_valid && s.tx.short_frame
    && s.tx.data[3:0] == tag_cmd_pkg::NAK_ARG && s.fsm == tag_cmd_pkg::ST_RX)
    else $error("out of range read not refused");
  a_full_read: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    exec_go && crc_ok && !s.compat_pend && s.len == tag_cmd_pkg::LEN_FAST
    && s.buff[0] == tag_cmd_pkg::CMD_FAST_READ && s.buff[1] == tag_cmd_pkg::FIRST_PAGE
    && s.buff[2] == LAST_PAGE && !read_locked |=> s.fsm == tag_cmd_pkg::ST_SEND)
    else $error("full range read refused");
  a_read_guard: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    exec_go && crc_ok && !s.compat_pend && s.buff[0] == tag_cmd_pkg::CMD_FAST_READ
    && read_locked && s.buff[2] >= s.prot_start |=> s.tx.short_frame && s.tx_valid)
    else $error("protected read served");
  a_auth_read: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    exec_go && crc_ok && !s.compat_pend && auth && s.len == tag_cmd_pkg::LEN_FAST
    && s.buff[0] == tag_cmd_pkg::CMD_FAST_READ && s.buff[2] <= LAST_PAGE
    && s.buff[1] <= s.buff[2] |=> s.fsm == tag_cmd_pkg::ST_SEND)
    else $error("authenticated read refused");
  a_pwd_hidden: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ce_in && s.fsm == tag_cmd_pkg::ST_SEND && s.crc_phase == 2'h0 && !s.cnt_mode
    && (!s.tx_valid || tx_ready_in) && (s.rd_page == PWD_PAGE || s.rd_page == PASSWORD_ACK_PAGE)
    |=> s.tx.data == 8'h00)
    else $error("password byte leaked");
  a_write_floor: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    exec_go && crc_ok && !s.compat_pend && s.buff[0] == tag_cmd_pkg::CMD_WRITE
    && s.buff[1] < tag_cmd_pkg::FIRST_WR_PAGE |=> s.tx.short_frame
    && s.fsm == tag_cmd_pkg::ST_RX)
    else $error("write below floor accepted");
  a_lock_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    exec_go && crc_ok && !s.compat_pend && s.buff[0] == tag_cmd_pkg::CMD_WRITE
    && page_locked(s.buff[1], static_bits, dyn_bits, s.ctrl[tag_cmd_pkg::CTRL_CFG_LOCK])
    |=> s.fsm == tag_cmd_pkg::ST_RX && s.tx.data[3:0] == tag_cmd_pkg::NAK_ARG)
    else $error("locked page written");
  a_tear_keep: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ce_in && s.fsm == tag_cmd_pkg::ST_PROG && s.tear_page && !field_in
    && !(avs_req_in.write && s.bus_ack) |=> $stable(s.mem) && s.fsm == tag_cmd_pkg::ST_RX)
    else $error("torn write changed page");
  a_counter_guard: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    exec_go && crc_ok && !s.compat_pend && s.buff[0] == tag_cmd_pkg::CMD_COUNTER
    && s.ctrl[tag_cmd_pkg::CTRL_CNT_PROT] && !auth |=> s.tx.short_frame && s.tx_valid)
    else $error("protected counter served");
  a_prog_store: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ce_in && s.fsm == tag_cmd_pkg::ST_PROG && field_in && s.prog_cnt == '0
    && (!s.tx_valid || tx_ready_in) && !(avs_req_in.write && s.bus_ack)
    |=> s.mem[$past(s.wr_page)] == $past(s.wr_data) && s.tx.data[3:0] == tag_cmd_pkg::ACK_CODE)
    else $error("page write not stored");
endmodule

// file: reader_model.sv
// reader model: frames commands with CRC_A and collects the tag's answer.
// assumes the handler's clock; the bench calls send and watches done.
`timescale 1ns/10ps
module reader_model (
  // clock
  input wire logic clk_in,
  // command bytes to the tag
  output tag_cmd_pkg::rx_t rx_out,
  output logic rx_valid_out,
  // answer from the tag
  input wire tag_cmd_pkg::tx_t tx_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out
);
  logic [7:0] resp[$];
  logic done = 1'b0;
  logic short_ans = 1'b0;
  logic slow = 1'b0;
  initial rx_out = '0;
  initial rx_valid_out = 1'b0;
  initial tx_ready_out = 1'b1;
  // crc low byte first; bad spoils the high byte; released line shows inverted data
  task automatic send(input logic [7:0] f[$], input logic bad);
    logic [15:0] c;
    c = tag_cmd_pkg::CRC_INIT;
    foreach (f[i]) begin
      c = c ^ {8'h00, f[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ tag_cmd_pkg::CRC_POLY : c >> 1;
    end
    f.push_back(c[7:0]);
    f.push_back(c[15:8] ^ {8{bad}});
    resp.delete();
    done = 1'b0;
    foreach (f[i]) begin
      rx_out <= '{data: f[i], last: i == f.size() - 1};
      rx_valid_out <= 1'b1;
      @(posedge clk_in);
    end
    rx_valid_out <= 1'b0;
    rx_out <= '{data: ~f[f.size() - 1], last: 1'b0};
  endtask
  // whole answer kept however long, no give-up limit of its own; slow stalls ready
  always @(posedge clk_in) begin
    if (tx_valid_in && tx_ready_out) begin
      resp.push_back(tx_in.data);
      short_ans = tx_in.short_frame;
      done = tx_in.last;
    end
    tx_ready_out <= !slow || !tx_ready_out;
  end
endmodule

// file: tag_memory_command_handler_test.sv
// self-checking bench for the tag command handler, frames sent through the reader model.
// assumes a short program time and the control registers on the Avalon-MM port.
`timescale 1ns/10ps
module tag_memory_command_handler_test;
  typedef logic [7:0] bq_t[$];
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic field = 1'b1;
  logic [31:0] rd;
  logic [31:0] readdata;
  logic waitreq;
  tag_cmd_pkg::avs_req_t avs_req = '0;
  tag_cmd_pkg::rx_t rx;
  tag_cmd_pkg::tx_t tx;
  logic rx_valid;
  logic tx_valid;
  logic tx_ready;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  // program time cut to 8 cycles so writes finish quickly
  tag_memory_command_handler #(.WRITE_CYCLES(8)) i_dut (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .ce_in(1'b1), .avs_req_in(avs_req), .avs_readdata_out(readdata),
    .avs_waitrequest_out(waitreq), .rx_in(rx), .rx_valid_in(rx_valid), .field_in(field),
    .tx_out(tx), .tx_valid_out(tx_valid), .tx_ready_in(tx_ready));
  reader_model m (.clk_in(clk_in), .rx_out(rx), .rx_valid_out(rx_valid), .tx_in(tx),
    .tx_valid_in(tx_valid), .tx_ready_out(tx_ready));
  initial forever #5 clk_in = ~clk_in;
  // a hang is cut short well past the longest expected run
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end
  task automatic finish_test;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic bq_t zeros(input int n);
    bq_t q;
    repeat (n) q.push_back(8'h00);
    return q;
  endfunction
  // request held until waitrequest is seen low at an edge, then released
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_req <= '{!w, w, a, d, 4'hF};
    do @(posedge clk_in); while (waitreq !== 1'b0);
    rd = readdata;
    avs_req <= '0;
    @(posedge clk_in);
  endtask
  // short answers compare the 4-bit code, data answers the payload and its length
  task automatic run(input bq_t f, input bq_t e, input logic sh, input logic bad = 1'b0);
    m.send(f, bad);
    wait (m.done === 1'b1);
    if (e.size() == 0) return;
    check({7'h00, m.short_ans}, {7'h00, sh});
    if (!sh) check(8'(m.resp.size()), 8'(e.size() + 2));
    foreach (e[i]) check(sh ? {4'h0, m.resp[i][3:0]} : m.resp[i], e[i]);
  endtask
  task automatic t_write_read;
    run({8'hA2,8'h04,8'h11,8'h22,8'h33,8'h44}, {8'h0A}, 1'b1);
    run({8'h3A,8'h04,8'h04}, {8'h11,8'h22,8'h33,8'h44}, 1'b0);
  endtask
  task automatic t_ranges;
    run({8'h3A,8'h2D,8'h2D}, {8'h00}, 1'b1);
    run({8'hA2,8'h01,8'hFF,8'hFF,8'hFF,8'hFF}, {8'h00}, 1'b1);
    run({8'hA0,8'h2D}, {8'h00}, 1'b1);
    run({8'hA2,8'h2C,8'h5A,8'h5A,8'h5A,8'h5A}, {8'h0A}, 1'b1);
    run({8'h3A,8'h01,8'h01}, zeros(4), 1'b0);
    run({8'h3A,8'h2B,8'h2C}, zeros(8), 1'b0);
    m.send({8'h3A,8'h00,8'h2C}, 1'b0);
    wait (m.done === 1'b1);
    check(8'(m.resp.size()), 8'hB6);
    check(m.resp[16], 8'h11);
  endtask
  task automatic t_legacy;
    bq_t f;
    f = {8'hA0,8'h55,8'h66,8'h77,8'h88};
    f = {f, zeros(12)};
    run({8'hA0,8'h05}, {8'h0A}, 1'b1);
    run(f[1:16], {8'h0A}, 1'b1);
    run({8'h3A,8'h05,8'h06}, f[1:8], 1'b0);
  endtask
  task automatic t_protect;
    bus(1'b0, 8'h04, 32'h0);
    check(rd[7:0], 8'hFF);
    bus(1'b0, 8'h40, 32'h0);
    check(rd[7:0], 8'h00);
    bus(1'b1, 8'h04, 32'h10);
    bus(1'b1, 8'h00, 32'h2);
    run({8'h3A,8'h0E,8'h10}, {8'h00}, 1'b1);
    run({8'h3A,8'h0E,8'h0F}, zeros(8), 1'b0);
    run({8'hA2,8'h10,8'h99,8'h98,8'h97,8'h96}, {8'h00}, 1'b1);
    bus(1'b1, 8'h00, 32'h3);
    run({8'hA2,8'h10,8'h99,8'h98,8'h97,8'h96}, {8'h0A}, 1'b1);
    run({8'h3A,8'h10,8'h10}, {8'h99,8'h98,8'h97,8'h96}, 1'b0);
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h04, 32'hFF);
  endtask
  task automatic t_counter;
    bus(1'b1, 8'h08, 32'h123456);
    bus(1'b1, 8'h00, 32'h4);
    m.slow <= 1'b1;
    run({8'h39,8'h02}, {8'h00}, 1'b1);
    bus(1'b1, 8'h00, 32'h5);
    run({8'h39,8'h02}, {8'h56,8'h34,8'h12}, 1'b0);
    m.slow <= 1'b0;
    bus(1'b1, 8'h00, 32'h0);
  endtask
  // field lost while page 3 programs: no answer and the page keeps its old bytes
  task automatic t_tear;
    m.send({8'hA2,8'h03,8'hE1,8'h10,8'h12,8'h00}, 1'b0);
    repeat (3) @(posedge clk_in);
    field <= 1'b0;
    repeat (2) @(posedge clk_in);
    field <= 1'b1;
    repeat (20) @(posedge clk_in);
    check({7'h00, m.done}, 8'h00);
    run({8'h3A,8'h03,8'h03}, zeros(4), 1'b0);
  endtask
  task automatic t_lock;
    run({8'hA2,8'h02,8'h00,8'h00,8'h10,8'h00}, {8'h0A}, 1'b1);
    run({8'hA2,8'h04,8'hAA,8'hBB,8'hCC,8'hDD}, {8'h00}, 1'b1);
    run({8'h3A,8'h04,8'h04}, {8'h11,8'h22,8'h33,8'h44}, 1'b0);
    run({8'hA2,8'h28,8'h01,8'h00,8'h00,8'h00}, {8'h0A}, 1'b1);
    run({8'hA2,8'h11,8'h01,8'h02,8'h03,8'h04}, {8'h00}, 1'b1);
    bus(1'b1, 8'h00, 32'h8);
    run({8'hA2,8'h2A,8'h01,8'h02,8'h03,8'h04}, {8'h00}, 1'b1);
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    t_write_read();
    t_ranges();
    t_legacy();
    t_protect();
    t_counter();
    run({8'h3A,8'h00,8'h00}, {8'h01}, 1'b1, 1'b1);
    t_tear();
    t_lock();
    finish_test();
  end
endmodule
